/* logic/cpu_iface_defs.svh */
// offsets, field positions and reset values of the processor interface output block
`ifndef CPU_IFACE_DEFS_SVH
`define CPU_IFACE_DEFS_SVH

// register byte offsets
`define OFF_CTRL    8'h00
`define OFF_GROUP   8'h04
`define OFF_STATUS  8'h08
`define OFF_ACK     8'h0c
`define OFF_APR     8'h10

// cpu_if_control field positions, secure view
`define CTL_G0EN    0
`define CTL_G1EN    1
`define CTL_FSEL    3
`define CTL_FOFF0   5
`define CTL_IOFF0   6
`define CTL_FOFF1   7
`define CTL_IOFF1   8

// cpu_if_control field positions, non-secure view
`define NS_G1EN     0
`define NS_FOFF1    5
`define NS_IOFF1    6

// status field positions
`define ST_IRQ      0
`define ST_FAST     1
`define ST_WIRQ     2
`define ST_WFAST    3
`define ST_PEND     4

// reset values and codes
`define CTL_RESET   7'h00
`define GROUP_RESET 32'h0000_0000
`define APR_RESET   32'h0000_0000
`define ACK_ID_W    5
`define ACK_NONE    32'h0000_03ff

`endif

/* logic/cpu_iface_irq_output_bypass.sv */
// processor interface: request output selection, grouping, banking and acknowledge
//
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`include "cpu_iface_defs.svh"
// Overview of operation
// - undriven irq follows legacy input unless irq bypass disable bits turn it off
// - irq driven by own logic per group enables and fast select, else deasserted
// - fast request driven by own logic when group 0 enable and fast select set
// - fast select on, group 0 off: fast bypass unless group 0 disable set
// - fast select off: fast bypass unless both fast disable bits set
// - wakeup signals come out of the output selection logic
// - wakeups stay available when signalling and bypass are both disabled
// - active priority state has secure and non-secure copies
// - out of reset all interrupts are group 0 and signalled on irq
// - each interrupt individually set to group 0 or group 1
// - interface can move group 0 signalling to the fast request
// - secure and non-secure accesses answered according to their state
// - some registers banked, copy chosen by access security state
// - some registers reachable by secure accesses only
// - remaining registers shared by both access states; non-secure acknowledge takes group 1 only
// - group 0 treated as secure, group 1 as non-secure
// - one interface per processor; security may exist on only some
// - software interrupts independent per processor; peripherals one-of-many
// - irq and fast request are active high at this level
// - peer acknowledge clears one-of-many pending, leaves software interrupts alone
module cpu_iface_irq_output_bypass #(
  parameter int          NUM_INTS    = 32,
  parameter int          SGI_COUNT   = 16,
  parameter int          APR_WIDTH   = 32,
  parameter logic        SECURITY_EN = 1'b1
) (
  // clock, reset, enable
  input  wire logic                    sys_clk,
  input  wire logic                    sys_rst,
  input  wire logic                    ce,
  // register port
  input  wire logic [7:0]              regAddr,
  input  wire logic [31:0]             regWdata,
  input  wire logic                    regWr,
  input  wire logic                    regRd,
  input  wire logic                    regNonSecure,
  output logic [31:0]                  regRdata,
  // interrupt sources and acknowledge broadcast
  input  wire logic [NUM_INTS-1:0]     intReq,
  input  wire cpu_iface_pkg::ack_bcast_t peerAck,
  output cpu_iface_pkg::ack_bcast_t    localAck,
  // legacy pins
  input  wire logic                    legacyIrq,
  input  wire logic                    legacyFast,
  // processor requests and wakeups
  output logic                         irqOut,
  output logic                         fastOut,
  output logic                         wakeIrq,
  output logic                         wakeFast
);
  // refuse configurations the id width or masks cannot serve
  if (NUM_INTS < 1 || NUM_INTS > 32 || SGI_COUNT < 0 || SGI_COUNT > NUM_INTS ||
      APR_WIDTH < 1 || APR_WIDTH > 32) begin : g_badcfg
    $error("cpu_iface_irq_output_bypass: unsupported parameters");
  end

  cpu_iface_pkg::cpu_if_control_t ctl_q;
  cpu_iface_pkg::pend_info_t      topInfo;
  logic [NUM_INTS-1:0]            group_q;
  logic [NUM_INTS-1:0]            pend_q;
  logic [APR_WIDTH-1:0]           aprS_q;
  logic [APR_WIDTH-1:0]           aprNs_q;
  logic                           legIrqMeta_q, legIrq_q;
  logic                           legFastMeta_q, legFast_q;
  logic                           isNs;
  logic [NUM_INTS-1:0]            ackMask;
  logic                           ackHit, ackTake;
  logic [`ACK_ID_W-1:0]           ackId, topId;
  logic                           wrCtrl, wrGroup, wrApr;
  logic [31:0]                    rdValue;
  logic [31:0]                    ctlView;

  // index of the lowest set bit, which stands in for highest priority here
  function automatic logic [`ACK_ID_W-1:0] firstSet(input logic [NUM_INTS-1:0] v);
    int i;
    firstSet = '0;
    for (i = NUM_INTS - 1; i >= 0; i--) begin
      if (v[i]) begin
        firstSet = i[`ACK_ID_W-1:0];
      end
    end
  endfunction

  // access security state; without security every access acts as secure
  assign isNs = SECURITY_EN & regNonSecure;

  // write decode
  always_comb begin
    wrCtrl  = 1'b0;
    wrGroup = 1'b0;
    wrApr   = 1'b0;
    if (regWr && regAddr == `OFF_CTRL) begin
      wrCtrl = 1'b1;
    end else if (regWr && regAddr == `OFF_GROUP) begin
      wrGroup = ~isNs;
    end else if (regWr && regAddr == `OFF_APR) begin
      wrApr = 1'b1;
    end
  end

  // legacy pins cross two flip-flops before use
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      legIrqMeta_q  <= 1'b0;
      legIrq_q      <= 1'b0;
      legFastMeta_q <= 1'b0;
      legFast_q     <= 1'b0;
    end else if (ce) begin
      legIrqMeta_q  <= legacyIrq;
      legIrq_q      <= legIrqMeta_q;
      legFastMeta_q <= legacyFast;
      legFast_q     <= legFastMeta_q;
    end
  end

  // control register: non-secure sees and writes only the group 1 bits
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctl_q <= cpu_iface_pkg::cpu_if_control_t'(`CTL_RESET);
    end else if (ce && wrCtrl) begin
      if (isNs) begin
        ctl_q.grp1SignalEn <= regWdata[`NS_G1EN];
        ctl_q.fastOffG1    <= regWdata[`NS_FOFF1];
        ctl_q.irqOffG1     <= regWdata[`NS_IOFF1];
      end else begin
        ctl_q.grp0SignalEn  <= regWdata[`CTL_G0EN];
        ctl_q.grp1SignalEn  <= regWdata[`CTL_G1EN];
        ctl_q.grp0OnFastSel <= regWdata[`CTL_FSEL];
        ctl_q.fastOffG0     <= regWdata[`CTL_FOFF0];
        ctl_q.irqOffG0      <= regWdata[`CTL_IOFF0];
        ctl_q.fastOffG1     <= regWdata[`CTL_FOFF1];
        ctl_q.irqOffG1      <= regWdata[`CTL_IOFF1];
      end
    end
  end

  // per-interrupt group bits, secure access only
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      group_q <= NUM_INTS'(`GROUP_RESET);
    end else if (ce && wrGroup) begin
      group_q <= regWdata[NUM_INTS-1:0];
    end
  end

  // banked active priority copies
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      aprS_q  <= APR_WIDTH'(`APR_RESET);
      aprNs_q <= APR_WIDTH'(`APR_RESET);
    end else if (ce && wrApr) begin
      if (isNs) begin
        aprNs_q <= regWdata[APR_WIDTH-1:0];
      end else begin
        aprS_q  <= regWdata[APR_WIDTH-1:0];
      end
    end
  end

  // acknowledge selection: non-secure reads take group 1 only
  always_comb begin
    ackMask = isNs ? (pend_q & group_q) : pend_q;
    ackHit  = |ackMask;
    ackId   = firstSet(ackMask);
    ackTake = ce & regRd & (regAddr == `OFF_ACK) & ackHit;
    topId   = firstSet(pend_q);
    topInfo.pending = |pend_q;
    topInfo.grp1    = group_q[topId];
  end

  // pending state per interrupt; a new request beats any clear
  for (genvar g = 0; g < NUM_INTS; g++) begin : g_pend
    logic clrLocal, clrPeer;
    assign clrLocal = ackTake && (ackId == `ACK_ID_W'(g));
    assign clrPeer  = peerAck.valid && (peerAck.id == `ACK_ID_W'(g)) &&
                      (g >= SGI_COUNT);
    always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
        pend_q[g] <= 1'b0;
      end else if (ce) begin
        if (intReq[g]) begin
          pend_q[g] <= 1'b1;
        end else if (clrLocal || clrPeer) begin
          pend_q[g] <= 1'b0;
        end
      end
    end
  end

  // broadcast our acknowledge to the other interfaces
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      localAck <= '0;
    end else if (ce) begin
      localAck.valid <= ackTake;
      localAck.id    <= ackId;
    end
  end

  // control register view by access state
  always_comb begin
    ctlView = '0;
    if (isNs) begin
      ctlView[`NS_G1EN]  = ctl_q.grp1SignalEn;
      ctlView[`NS_FOFF1] = ctl_q.fastOffG1;
      ctlView[`NS_IOFF1] = ctl_q.irqOffG1;
    end else begin
      ctlView[`CTL_G0EN]  = ctl_q.grp0SignalEn;
      ctlView[`CTL_G1EN]  = ctl_q.grp1SignalEn;
      ctlView[`CTL_FSEL]  = ctl_q.grp0OnFastSel;
      ctlView[`CTL_FOFF0] = ctl_q.fastOffG0;
      ctlView[`CTL_IOFF0] = ctl_q.irqOffG0;
      ctlView[`CTL_FOFF1] = ctl_q.fastOffG1;
      ctlView[`CTL_IOFF1] = ctl_q.irqOffG1;
    end
  end

  // read decode; unmapped addresses read zero
  always_comb begin
    rdValue = '0;
    if (regAddr == `OFF_CTRL) begin
      rdValue = ctlView;
    end else if (regAddr == `OFF_GROUP) begin
      rdValue[NUM_INTS-1:0] = isNs ? '0 : group_q;
    end else if (regAddr == `OFF_STATUS) begin
      rdValue[`ST_IRQ]   = irqOut;
      rdValue[`ST_FAST]  = fastOut;
      rdValue[`ST_WIRQ]  = wakeIrq;
      rdValue[`ST_WFAST] = wakeFast;
      rdValue[`ST_PEND]  = topInfo.pending;
    end else if (regAddr == `OFF_ACK) begin
      rdValue = ackHit ? {{(32-`ACK_ID_W){1'b0}}, ackId} : `ACK_NONE;
    end else if (regAddr == `OFF_APR) begin
      rdValue[APR_WIDTH-1:0] = isNs ? aprNs_q : aprS_q;
    end
  end

  // read data stand for exactly the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      regRdata <= '0;
    end else if (ce) begin
      regRdata <= regRd ? rdValue : '0;
    end
  end

  // output selection and wakeups
  irq_out_select u_sel (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .ce       (ce),
    .ctl      (ctl_q),
    .topPend  (topInfo),
    .legIrq   (legIrq_q),
    .legFast  (legFast_q),
    .irqOut   (irqOut),
    .fastOut  (fastOut),
    .wakeIrq  (wakeIrq),
    .wakeFast (wakeFast)
  );

  sequence ackEmptyRead;
    ce && regRd && regAddr == `OFF_ACK && !ackHit;
  endsequence

  sequence nsApr;
    ce && regWr && isNs && regAddr == `OFF_APR;
  endsequence

  grpSecure_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (ce && regWr && isNs && regAddr == `OFF_GROUP) |=> $stable(group_q))
    else $error("non-secure write changed group bits");
  aprBank_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    nsApr |=> ($stable(aprS_q) && aprNs_q == $past(regWdata[APR_WIDTH-1:0])))
    else $error("non-secure write disturbed secure copy");
  nsAckGrp_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (ackTake && isNs) |-> group_q[ackId])
    else $error("non-secure acknowledge took group 0");
  ackNone_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ackEmptyRead |=> (regRdata == `ACK_NONE))
    else $error("empty acknowledge code wrong");
  setWins_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (ackTake && intReq[ackId]) |=> pend_q[$past(ackId)])
    else $error("request lost against acknowledge");
  peerSgi_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (ce && peerAck.valid && peerAck.id < SGI_COUNT && !ackTake && !intReq[peerAck.id]) |=>
    (pend_q[$past(peerAck.id)] == $past(pend_q[peerAck.id])))
    else $error("peer acknowledge touched software interrupt");
  peerSpi_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (ce && peerAck.valid && peerAck.id >= SGI_COUNT && peerAck.id < NUM_INTS &&
    !intReq[peerAck.id]) |=> !pend_q[$past(peerAck.id)])
    else $error("peer acknowledge left peripheral pending");
  resetGrp_a: assert property (@(posedge sys_clk)
    $past(sys_rst) |-> (group_q == '0 && !ctl_q.grp0OnFastSel && !irqOut))
    else $error("reset state not group 0 on irq");
endmodule

/* logic/cpu_iface_pkg.sv */
// types shared by the processor interface output block
package cpu_iface_pkg;
  `include "cpu_iface_defs.svh"

  // control bits steering the two request outputs
  typedef struct packed {
    logic irqOffG1;
    logic fastOffG1;
    logic irqOffG0;
    logic fastOffG0;
    logic grp0OnFastSel;
    logic grp1SignalEn;
    logic grp0SignalEn;
  } cpu_if_control_t;

  // acknowledge broadcast between processor interfaces
  typedef struct packed {
    logic                 valid;
    logic [`ACK_ID_W-1:0] id;
  } ack_bcast_t;

  // highest pending interrupt, enables not applied, seen by the output selection
  typedef struct packed {
    logic pending;
    logic grp1;
  } pend_info_t;
endpackage

/* logic/irq_out_select.sv */
// output selection for irq and fast request: own logic, legacy bypass or deasserted
`timescale 1ns/100ps
`include "cpu_iface_defs.svh"
module irq_out_select (
  // clock, reset, enable
  input  wire logic                          sys_clk,
  input  wire logic                          sys_rst,
  input  wire logic                          ce,
  // control and state
  input  wire cpu_iface_pkg::cpu_if_control_t ctl,
  input  wire cpu_iface_pkg::pend_info_t      topPend,
  input  wire logic                          legIrq,
  input  wire logic                          legFast,
  // request and wakeup outputs
  output logic                               irqOut,
  output logic                               fastOut,
  output logic                               wakeIrq,
  output logic                               wakeFast
);
  logic irqDriven, irqOwn, irqBypOff, irqD;
  logic fastDriven, fastOwn, fastBypOff, fastD;
  logic wakeIrqD, wakeFastD;

  // combinational choice of source for each output
  always_comb begin
    irqDriven  = ctl.grp1SignalEn | (ctl.grp0SignalEn & ~ctl.grp0OnFastSel);
    irqOwn     = topPend.pending & (topPend.grp1 ? ctl.grp1SignalEn
                 : (ctl.grp0SignalEn & ~ctl.grp0OnFastSel));
    irqBypOff  = ctl.irqOffG1 & (~ctl.grp0OnFastSel | ctl.irqOffG0);
    irqD       = irqDriven ? irqOwn : (~irqBypOff & legIrq);
    fastDriven = ctl.grp0SignalEn & ctl.grp0OnFastSel;
    fastOwn    = topPend.pending & ~topPend.grp1;
    fastBypOff = ctl.grp0OnFastSel ? ctl.fastOffG0
                 : (ctl.fastOffG0 & ctl.fastOffG1);
    fastD      = fastDriven ? fastOwn : (~fastBypOff & legFast);
    // wakeups ignore enables and bypass disables
    wakeIrqD   = legIrq | (topPend.pending & (topPend.grp1 | ~ctl.grp0OnFastSel));
    wakeFastD  = legFast | (topPend.pending & ~topPend.grp1 & ctl.grp0OnFastSel);
  end

  // one register stage keeps the outputs glitch free
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irqOut   <= 1'b0;
      fastOut  <= 1'b0;
      wakeIrq  <= 1'b0;
      wakeFast <= 1'b0;
    end else if (ce) begin
      irqOut   <= irqD;
      fastOut  <= fastD;
      wakeIrq  <= wakeIrqD;
      wakeFast <= wakeFastD;
    end
  end

  irqOff_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (ce && !irqDriven && irqBypOff) |=> !irqOut)
    else $error("irq not deasserted with bypass disabled");
  irqOwn_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (ce && ctl.grp1SignalEn && topPend.pending && topPend.grp1) |=> irqOut)
    else $error("irq not driven for pending group 1");
  fastOwn_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (ce && fastDriven) |=> (fastOut == $past(topPend.pending & ~topPend.grp1)))
    else $error("fast request not driven by own logic");
  fastSel_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (ce && ctl.grp0OnFastSel && !ctl.grp0SignalEn && !ctl.fastOffG0) |=>
    (fastOut == $past(legFast)))
    else $error("fast request bypass lost");
  fastNoSel_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (ce && !ctl.grp0OnFastSel && ctl.fastOffG0 && ctl.fastOffG1) |=> !fastOut)
    else $error("fast request not deasserted");
  wakeKeep_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (ce && legIrq && !irqDriven && irqBypOff) |=> (wakeIrq && !irqOut))
    else $error("wakeup lost while output disabled");
endmodule

/* testbench/cpu_core_model.sv */
// processor core model: takes the active-high irq and fast requests and counts each one raised
`timescale 1ns/100ps
module cpu_core_model (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  // request lines from the interface
  input  wire logic       irqReq,
  input  wire logic       fastReq,
  // number of requests taken
  output logic [7:0]      irqTaken,
  output logic [7:0]      fastTaken
);
  logic irqPrev_q;
  logic fastPrev_q;

  // a request is taken on its rising level, high means asserted
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      irqPrev_q  <= 1'b0;
      fastPrev_q <= 1'b0;
      irqTaken   <= 8'h00;
      fastTaken  <= 8'h00;
    end else begin
      irqPrev_q  <= irqReq;
      fastPrev_q <= fastReq;
      if (irqReq && !irqPrev_q) irqTaken <= irqTaken + 8'h01;
      if (fastReq && !fastPrev_q) fastTaken <= fastTaken + 8'h01;
    end
  end
endmodule

/* testbench/tb.sv */
// self-checking bench for the request output selection block
`timescale 1ns/100ps
`include "cpu_iface_defs.svh"
`define CHK(got, exp) begin samplesChecked++; if ((got) !== (exp)) begin errTotal++; \
  $display("[ERR] %0t mismatch got %h exp %h", $time, (got), (exp)); end end
module tb;
  typedef struct packed {
    logic [6:0] c;
    logic       g1;
    logic       li;
    logic       lf;
    logic       ei;
    logic       ef;
  } row_t;

  logic                      sys_clk;
  logic                      sys_rst;
  logic                      ce;
  logic [7:0]                regAddr;
  logic [31:0]               regWdata;
  logic                      regWr;
  logic                      regRd;
  logic                      regNonSecure;
  logic [31:0]               regRdata;
  logic [31:0]               intReq;
  cpu_iface_pkg::ack_bcast_t peerAck;
  cpu_iface_pkg::ack_bcast_t localAck;
  logic                      legacyIrq;
  logic                      legacyFast;
  logic                      irqOut;
  logic                      fastOut;
  logic                      wakeIrq;
  logic                      wakeFast;
  logic [7:0]                irqTaken;
  logic [7:0]                fastTaken;
  logic [4:0]                lastAckId;
  int                        errTotal;
  int                        samplesChecked;
  logic [7:0]                takenBefore;
  logic                      pendIrq;
  logic                      pendFast;

  // ctl bits {irqOffG1,fastOffG1,irqOffG0,fastOffG0,fastSel,g1En,g0En}, group, legacy, expected
  row_t rows [18] = '{
    '{7'h00, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1}, '{7'h00, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0},
    '{7'h40, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1}, '{7'h44, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1},
    '{7'h54, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1}, '{7'h29, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0},
    '{7'h01, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1}, '{7'h0d, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0},
    '{7'h55, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1}, '{7'h02, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1},
    '{7'h02, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1}, '{7'h03, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1},
    '{7'h07, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1}, '{7'h07, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0},
    '{7'h0c, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0}, '{7'h08, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1},
    '{7'h20, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1}, '{7'h24, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1}
  };

  cpu_iface_irq_output_bypass DUT (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .ce(ce),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regNonSecure(regNonSecure), .regRdata(regRdata),
    .intReq(intReq), .peerAck(peerAck), .localAck(localAck),
    .legacyIrq(legacyIrq), .legacyFast(legacyFast),
    .irqOut(irqOut), .fastOut(fastOut), .wakeIrq(wakeIrq), .wakeFast(wakeFast)
  );

  cpu_core_model core (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .irqReq(irqOut), .fastReq(fastOut),
    .irqTaken(irqTaken), .fastTaken(fastTaken)
  );

  // clock at 40 ns
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // remember the id of the last acknowledge sent to the peers
  always @(posedge sys_clk) begin
    if (localAck.valid === 1'b1) lastAckId <= localAck.id;
  end

  // secure view of the control word built from the packed bit order
  function automatic logic [31:0] ctlWord(logic [6:0] c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`CTL_G0EN]  = c[0];
    w[`CTL_G1EN]  = c[1];
    w[`CTL_FSEL]  = c[2];
    w[`CTL_FOFF0] = c[3];
    w[`CTL_IOFF0] = c[4];
    w[`CTL_FOFF1] = c[5];
    w[`CTL_IOFF1] = c[6];
    return w;
  endfunction

  task automatic wr(logic [7:0] a, logic [31:0] d, logic ns);
    @(posedge sys_clk);
    regWr <= 1'b1; regAddr <= a; regWdata <= d; regNonSecure <= ns;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask

  // read data stand in the cycle after the strobe only
  task automatic rd(logic [7:0] a, logic ns, logic [31:0] exp);
    @(posedge sys_clk);
    regRd <= 1'b1; regAddr <= a; regNonSecure <= ns;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1;
    `CHK(regRdata, exp)
  endtask

  task automatic pulse(int n);
    @(posedge sys_clk);
    intReq[n] <= 1'b1;
    @(posedge sys_clk);
    intReq <= 32'h0000_0000;
  endtask

  task automatic peer(logic [4:0] id);
    @(posedge sys_clk);
    peerAck <= '{valid: 1'b1, id: id};
    @(posedge sys_clk);
    peerAck <= '{valid: 1'b0, id: 5'h00};
  endtask

  task automatic settle();
    repeat (4) @(posedge sys_clk);
    #1;
  endtask

  task automatic reportAndStop();
    $display("checks %0d mismatches %0d", samplesChecked, errTotal);
    if (errTotal == 0 && samplesChecked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // hang guard
  initial begin
    repeat (20000) @(posedge sys_clk);
    errTotal++;
    $display("[ERR] %0t run timed out", $time);
    reportAndStop();
  end

  initial begin
    errTotal = 0; samplesChecked = 0; sys_rst = 1'b1; regAddr = 8'h00; regWdata = 32'h0;
    regWr = 1'b0; regRd = 1'b0; regNonSecure = 1'b0; intReq = 32'h0; ce = 1'b1;
    peerAck = '{valid: 1'b0, id: 5'h00}; legacyIrq = 1'b0; legacyFast = 1'b0;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    #1;
    `CHK({irqOut, fastOut, regRdata}, 34'h0)
    rd(`OFF_CTRL, 1'b0, 32'h0);
    rd(`OFF_GROUP, 1'b0, `GROUP_RESET);
    rd(`OFF_APR, 1'b0, `APR_RESET);
    // default grouping signals on irq
    takenBefore = irqTaken;
    wr(`OFF_CTRL, ctlWord(7'h01), 1'b0);
    pulse(4);
    settle();
    `CHK({irqOut, fastOut}, 2'b10)
    `CHK(irqTaken, takenBefore + 8'h01)
    rd(`OFF_STATUS, 1'b0, 32'h0000_0015);
    rd(`OFF_ACK, 1'b0, 32'h0000_0004);
    // interrupt 20 becomes group 1, 4 stays group 0
    wr(`OFF_GROUP, 32'h0010_0000, 1'b0);
    rd(`OFF_GROUP, 1'b0, 32'h0010_0000);
    foreach (rows[i]) begin
      @(posedge sys_clk);
      legacyIrq <= rows[i].li;
      legacyFast <= rows[i].lf;
      wr(`OFF_CTRL, ctlWord(rows[i].c), 1'b0);
      pulse(rows[i].g1 ? 20 : 4);
      settle();
      pendIrq = rows[i].g1 | ~rows[i].c[2];
      pendFast = ~rows[i].g1 & rows[i].c[2];
      `CHK({irqOut, fastOut}, {rows[i].ei, rows[i].ef})
      `CHK({wakeIrq, wakeFast}, {rows[i].li | pendIrq, rows[i].lf | pendFast})
      rd(`OFF_ACK, 1'b0, rows[i].g1 ? 32'h14 : 32'h4);
    end
    // shared control bits with non-secure view, banked active priority and secure-only grouping
    wr(`OFF_CTRL, ctlWord(7'h63), 1'b0);
    rd(`OFF_CTRL, 1'b1, 32'h0000_0061);
    wr(`OFF_CTRL, 32'h0, 1'b1);
    rd(`OFF_CTRL, 1'b0, ctlWord(7'h01));
    wr(`OFF_GROUP, 32'hffff_ffff, 1'b1);
    rd(`OFF_GROUP, 1'b1, 32'h0);
    rd(`OFF_GROUP, 1'b0, 32'h0010_0000);
    wr(`OFF_APR, 32'h1234_5678, 1'b0);
    wr(`OFF_APR, 32'h0000_abcd, 1'b1);
    rd(`OFF_APR, 1'b0, 32'h1234_5678);
    rd(`OFF_APR, 1'b1, 32'h0000_abcd);
    wr(8'h20, 32'hffff_ffff, 1'b0);
    rd(8'h20, 1'b0, 32'h0);
    // peer acknowledges: software ids stay, peripheral ids cleared
    pulse(3);
    pulse(20);
    peer(5'h03);
    peer(5'h14);
    rd(`OFF_ACK, 1'b0, 32'h0000_0003);
    repeat (2) @(posedge sys_clk);
    `CHK(lastAckId, 5'h03)
    rd(`OFF_ACK, 1'b0, `ACK_NONE);
    // non-secure acknowledge sees group 1 only
    pulse(4);
    pulse(20);
    rd(`OFF_ACK, 1'b1, 32'h0000_0014);
    rd(`OFF_ACK, 1'b1, `ACK_NONE);
    rd(`OFF_ACK, 1'b0, 32'h0000_0004);
    // acknowledge and a new request in one cycle: the request keeps it pending
    pulse(7);
    @(posedge sys_clk);
    regRd <= 1'b1;
    regAddr <= `OFF_ACK;
    regNonSecure <= 1'b0;
    intReq[7] <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    intReq <= 32'h0000_0000;
    #1;
    `CHK(regRdata, 32'h0000_0007)
    rd(`OFF_ACK, 1'b0, 32'h0000_0007);
    rd(`OFF_ACK, 1'b0, `ACK_NONE);
    // second reset in mid-run
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    #1;
    `CHK({irqOut, fastOut, wakeIrq, wakeFast}, 4'h0)
    rd(`OFF_CTRL, 1'b0, 32'h0);
    rd(`OFF_GROUP, 1'b0, `GROUP_RESET);
    // clock enable low freezes the bypassed outputs while the legacy pins fall
    @(posedge sys_clk);
    ce <= 1'b0;
    legacyIrq <= 1'b0;
    legacyFast <= 1'b0;
    settle();
    `CHK({irqOut, fastOut}, 2'b11)
    @(posedge sys_clk);
    ce <= 1'b1;
    settle();
    `CHK({irqOut, fastOut}, 2'b00)
    reportAndStop();
  end
endmodule
